// File: sev_point_capture.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module sev_point_capture #(
    parameter int N_IN = 16,
    parameter int TIME_W = 32,
    parameter int RPI_W = 20,
    parameter int TICK_DIV = sev_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_IN-1:0] din,
    output logic [N_IN-1:0] point_lost_event_flag,
    output logic data_produce,
    output logic irq
);
    localparam int N_SLOT = 2 * N_IN;
    localparam int SLOT_IW = $clog2(N_SLOT);
    localparam logic [RPI_W-1:0] RPI_RESET = RPI_W'(sev_pkg::RPI_DEFAULT_US);
    localparam logic [RPI_W-1:0] RPI_MIN = RPI_W'(sev_pkg::RPI_MIN_US);
    localparam logic [RPI_W-1:0] RPI_MAX = RPI_W'(sev_pkg::RPI_MAX_US);
    localparam logic [11:0] SLOT_END = sev_pkg::SLOT_BASE + 12'(4 * N_SLOT);

    sev_time_if #(.TIME_W(TIME_W), .RPI_W(RPI_W)) tif ();

    logic [31:0] ctrl_reg;
    logic [N_SLOT-1:0] capen_reg;
    logic [N_SLOT-1:0] full_reg;
    logic [sev_pkg::INT_W-1:0] int_stat_reg;
    logic [sev_pkg::INT_W-1:0] int_mask_reg;
    logic [RPI_W-1:0] rpi_reg;
    logic [TIME_W-1:0] slot_ts_reg [N_SLOT];
    logic [N_IN-1:0] in_state;
    logic [N_IN-1:0] rise;
    logic [N_IN-1:0] fall;
    logic [N_SLOT-1:0] edge_ok;
    logic [N_SLOT-1:0] ack_w;
    logic [N_SLOT-1:0] cap_take;
    logic [N_SLOT-1:0] lost_slot;
    logic [N_IN-1:0] lost_in;
    logic [N_IN-1:0] ovf_clr;
    logic [sev_pkg::INT_W-1:0] int_clr;
    logic [sev_pkg::INT_W-1:0] int_set;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_en;
    logic hold;
    logic mode_on;
    logic [RPI_W-1:0] rpi_wr;

    sev_timebase #(
        .TIME_W(TIME_W),
        .RPI_W(RPI_W),
        .TICK_DIV(TICK_DIV)
    ) u_timebase (
        .clk(clk),
        .reset(reset),
        .tif(tif)
    );

    sev_edge_detect #(
        .N(N_IN)
    ) u_edges (
        .clk(clk),
        .reset(reset),
        .din(din),
        .state(in_state),
        .rise(rise),
        .fall(fall)
    );

    // Slot index from a slot-window byte address
    function automatic logic [SLOT_IW-1:0] slot_index(input logic [11:0] addr);
        logic [11:0] rel;
        rel = addr - sev_pkg::SLOT_BASE;
        return rel[SLOT_IW+1:2];
    endfunction

    // Module-wide settings
    assign hold = ctrl_reg[sev_pkg::CTRL_HOLD_BIT];
    assign mode_on = ctrl_reg[sev_pkg::CTRL_MODE_BIT];

    // Write strobe: last edge of the access phase only
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign wmask = sev_pkg::strb_mask(pstrb);

    // Slot k below N_IN is the off-to-on slot of input k, the rest on-to-off
    always_comb begin
        edge_ok = {fall, rise} & capen_reg & {N_SLOT{mode_on}};
        ack_w = '0;
        if (wr_en && paddr == sev_pkg::ACK_OFS) begin
            ack_w = pwdata[N_SLOT-1:0] & wmask[N_SLOT-1:0];
        end
        // Same-cycle acknowledge frees the slot before the new edge lands
        lost_slot = edge_ok & full_reg & ~ack_w;
        cap_take = hold ? (edge_ok & ~lost_slot) : edge_ok;
        lost_in = lost_slot[N_IN-1:0] | lost_slot[N_SLOT-1:N_IN];
    end

    // Occupancy per slot: acknowledge clears, capture sets
    always_ff @(posedge clk) begin
        if (reset) begin
            full_reg <= '0;
        end else begin
            full_reg <= (full_reg & ~ack_w) | cap_take;
        end
    end

    // Timestamp storage, one word per input and direction
    always_ff @(posedge clk) begin
        for (int k = 0; k < N_SLOT; k++) begin
            if (cap_take[k]) begin
                slot_ts_reg[k] <= tif.now;
            end
        end
    end

    // Lost flags are sticky; a new loss wins over a clear
    always_comb begin
        ovf_clr = '0;
        if (wr_en && paddr == sev_pkg::OVF_OFS) begin
            ovf_clr = pwdata[N_IN-1:0] & wmask[N_IN-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            point_lost_event_flag <= '0;
        end else begin
            point_lost_event_flag <= (point_lost_event_flag & ~ovf_clr) | lost_in;
        end
    end

    // Produce pulse after each capture and at each packet interval
    assign tif.rpi_restart = |cap_take;
    assign tif.rpi_us = rpi_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            data_produce <= 1'b0;
        end else begin
            data_produce <= (|cap_take) | tif.rpi_due;
        end
    end

    // Merged write value for read-write registers
    always_comb begin
        merged = 32'h0000_0000;
        case (paddr)
            sev_pkg::CTRL_OFS: merged = sev_pkg::merge_write(ctrl_reg, pwdata, pstrb);
            sev_pkg::CAPEN_OFS: merged = (32'(capen_reg) & ~wmask) | (pwdata & wmask);
            sev_pkg::INT_MASK_OFS: merged = (32'(int_mask_reg) & ~wmask) | (pwdata & wmask);
            sev_pkg::RPI_OFS: merged = (32'(rpi_reg) & ~wmask) | (pwdata & wmask);
            default: merged = 32'h0000_0000;
        endcase
    end

    // Interval writes are clamped into the legal range
    always_comb begin
        rpi_wr = merged[RPI_W-1:0];
        if (rpi_wr < RPI_MIN) begin
            rpi_wr = RPI_MIN;
        end else if (rpi_wr > RPI_MAX) begin
            rpi_wr = RPI_MAX;
        end
    end

    // Control: hold defaults to on for every input together
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= sev_pkg::CTRL_RESET;
        end else if (wr_en && paddr == sev_pkg::CTRL_OFS) begin
            ctrl_reg <= merged & sev_pkg::CTRL_RESET;
        end
    end

    // Capture enables and packet interval
    always_ff @(posedge clk) begin
        if (reset) begin
            capen_reg <= sev_pkg::CAPEN_RESET[N_SLOT-1:0];
            rpi_reg <= RPI_RESET;
        end else if (wr_en) begin
            if (paddr == sev_pkg::CAPEN_OFS) begin
                capen_reg <= merged[N_SLOT-1:0];
            end
            if (paddr == sev_pkg::RPI_OFS) begin
                rpi_reg <= rpi_wr;
            end
        end
    end

    // Interrupt events and write-one-to-clear
    always_comb begin
        int_set = '0;
        int_set[sev_pkg::INT_CAPTURE] = |cap_take;
        int_set[sev_pkg::INT_LOST] = |lost_in;
        int_set[sev_pkg::INT_PACKET] = tif.rpi_due;
        int_clr = '0;
        if (wr_en && paddr == sev_pkg::INT_STAT_OFS) begin
            int_clr = pwdata[sev_pkg::INT_W-1:0] & wmask[sev_pkg::INT_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            int_stat_reg <= '0;
            int_mask_reg <= sev_pkg::MASK_RESET[sev_pkg::INT_W-1:0];
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
            if (wr_en && paddr == sev_pkg::INT_MASK_OFS) begin
                int_mask_reg <= merged[sev_pkg::INT_W-1:0];
            end
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // Read decode; unmapped addresses answer with an error
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            sev_pkg::CTRL_OFS: rd_data = ctrl_reg;
            sev_pkg::CAPEN_OFS: rd_data[N_SLOT-1:0] = capen_reg;
            sev_pkg::INSTATE_OFS: rd_data[N_IN-1:0] = in_state;
            sev_pkg::OVF_OFS: rd_data[N_IN-1:0] = point_lost_event_flag;
            sev_pkg::FULL_OFS: rd_data[N_SLOT-1:0] = full_reg;
            sev_pkg::ACK_OFS: rd_data = 32'h0000_0000;
            sev_pkg::TIME_OFS: rd_data[TIME_W-1:0] = tif.now;
            sev_pkg::INT_STAT_OFS: rd_data[sev_pkg::INT_W-1:0] = int_stat_reg;
            sev_pkg::INT_MASK_OFS: rd_data[sev_pkg::INT_W-1:0] = int_mask_reg;
            sev_pkg::RPI_OFS: rd_data[RPI_W-1:0] = rpi_reg;
            default: begin
                if (paddr >= sev_pkg::SLOT_BASE && paddr < SLOT_END && paddr[1:0] == 2'b00) begin
                    rd_data[TIME_W-1:0] = slot_ts_reg[slot_index(paddr)];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // APB answer: data latched in setup, ready for exactly one access cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !rd_hit;
            prdata <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_data;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

// File: sev_pkg.sv
package sev_pkg;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] CAPEN_OFS = 12'h004;
    localparam logic [11:0] INSTATE_OFS = 12'h008;
    localparam logic [11:0] OVF_OFS = 12'h00C;
    localparam logic [11:0] FULL_OFS = 12'h010;
    localparam logic [11:0] ACK_OFS = 12'h014;
    localparam logic [11:0] TIME_OFS = 12'h018;
    localparam logic [11:0] INT_STAT_OFS = 12'h01C;
    localparam logic [11:0] INT_MASK_OFS = 12'h020;
    localparam logic [11:0] RPI_OFS = 12'h024;
    localparam logic [11:0] SLOT_BASE = 12'h100;

    // Control register fields and reset value; capture-enable and mask reset values
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [31:0] CAPEN_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // Interrupt status bit positions
    localparam int INT_CAPTURE = 0;
    localparam int INT_LOST = 1;
    localparam int INT_PACKET = 2;
    localparam int INT_W = 3;

    // Timing: clock, time counter tick and packet interval limits
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ORDER_RESOLUTION_US = 25;
    localparam int RPI_DEFAULT_US = 10000;
    localparam int RPI_MIN_US = 200;
    localparam int RPI_MAX_US = 750000;

    // Expand APB byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    // Byte-lane merge of write data into an old value
    function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wdata,
                                                input logic [3:0] strb);
        logic [31:0] m;
        m = strb_mask(strb);
        return (old & ~m) | (wdata & m);
    endfunction

endpackage

// File: sev_time_if.sv
`timescale 1ns/100ps
interface sev_time_if #(
    parameter int TIME_W = 32,
    parameter int RPI_W = 20
);
    logic [TIME_W-1:0] now;
    logic tick;
    logic [RPI_W-1:0] rpi_us;
    logic rpi_restart;
    logic rpi_due;

    modport tb (input rpi_us, input rpi_restart, output now, output tick, output rpi_due);
    modport core (output rpi_us, output rpi_restart, input now, input tick, input rpi_due);
endinterface

// File: sev_timebase.sv
`timescale 1ns/100ps
module sev_timebase #(
    parameter int TIME_W = 32,
    parameter int RPI_W = 20,
    parameter int TICK_DIV = sev_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    sev_time_if.tb tif
);
    localparam int DIV_W = $clog2(TICK_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    logic [DIV_W-1:0] div_reg;
    logic [RPI_W-1:0] rpi_cnt_reg;

    // One-cycle tick every microsecond
    always_ff @(posedge clk) begin
        if (reset) begin
            div_reg <= '0;
            tif.tick <= 1'b0;
        end else begin
            tif.tick <= (div_reg == DIV_LAST);
            div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
        end
    end

    // Free-running time counter, 1 us per count, far finer than 25 us
    always_ff @(posedge clk) begin
        if (reset) begin
            tif.now <= '0;
        end else if (tif.tick) begin
            tif.now <= tif.now + 1'b1;
        end
    end

    // Packet interval timer; restarts whenever data was just produced
    always_ff @(posedge clk) begin
        if (reset) begin
            rpi_cnt_reg <= '0;
            tif.rpi_due <= 1'b0;
        end else begin
            tif.rpi_due <= 1'b0;
            if (tif.rpi_restart) begin
                rpi_cnt_reg <= '0;
            end else if (tif.tick) begin
                if (rpi_cnt_reg + 1'b1 >= tif.rpi_us) begin
                    rpi_cnt_reg <= '0;
                    tif.rpi_due <= 1'b1;
                end else begin
                    rpi_cnt_reg <= rpi_cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule

// File: sev_edge_detect.sv
`timescale 1ns/100ps
module sev_edge_detect #(
    parameter int N = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N-1:0] din,
    output logic [N-1:0] state,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);
    logic [N-1:0] prev_reg;
    logic primed_reg;

    // First sample after reset only primes, so a high input is no edge
    always_ff @(posedge clk) begin
        if (reset) begin
            prev_reg <= '0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg <= din;
            primed_reg <= 1'b1;
        end
    end

    // Edge flags relative to the last clocked sample
    assign state = prev_reg;
    assign rise = primed_reg ? (din & ~prev_reg) : '0;
    assign fall = primed_reg ? (~din & prev_reg) : '0;
endmodule

// File: sev_capture_monitor.sv
`timescale 1ns/100ps
module sev_capture_monitor #(
    parameter int N_IN = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [N_IN-1:0] din,
    input wire logic [N_IN-1:0] point_lost_event_flag,
    input wire logic data_produce,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Access phase of a write to the lost-flag register
    logic ovf_wr;
    assign ovf_wr = psel && penable && pwrite && (paddr == sev_pkg::OVF_OFS);

    // Setup phase of a transfer
    sequence setup_s;
        psel && !penable;
    endsequence

    // Full clear with no input edge at the same edge, so set cannot win
    sequence lost_clear_s;
        ovf_wr && pwdata == 32'hFFFF_FFFF && pstrb == 4'hF && $stable(din);
    endsequence

    a_ready_after_setup: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("pready without setup");
    a_idle_quiet: assert property (!psel |=> !pready)
        else $error("pready while idle");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("bad error response");
    a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data on write");
    a_lost_sticky: assert property (
        !ovf_wr |=> (point_lost_event_flag & $past(point_lost_event_flag))
            == $past(point_lost_event_flag))
        else $error("lost flag dropped");
    a_lost_cause: assert property (
        (point_lost_event_flag & ~$past(point_lost_event_flag)) != '0
            |-> $past(din) != $past(din, 2))
        else $error("lost flag without input edge");
    a_lost_clear: assert property (lost_clear_s |=> point_lost_event_flag == '0)
        else $error("lost flag not cleared");
endmodule

// File: sev_owner_model.sv
`timescale 1ns/100ps
module sev_owner_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic data_produce,
    output int produced
);
    // Consume each produced data set; count only, the bench does the acks
    always_ff @(posedge clk) begin
        if (reset) begin
            produced <= 0;
        end else if (data_produce) begin
            produced <= produced + 1;
        end
    end
endmodule

// File: tb_per_point_event_timestamp.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_per_point_event_timestamp;
    typedef struct {logic [11:0] addr; logic [31:0] exp;} sev_row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [15:0] din = 16'h0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] point_lost_event_flag;
    logic data_produce;
    logic irq;
    int produced;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int cnt0;
    logic [31:0] rd, t0, ts, ts2;
    logic err;
    // Reset values of eight of the readable registers
    sev_row_t rows [8] = '{'{sev_pkg::CTRL_OFS, sev_pkg::CTRL_RESET},
        '{sev_pkg::CAPEN_OFS, sev_pkg::CAPEN_RESET}, '{sev_pkg::INT_MASK_OFS, sev_pkg::MASK_RESET},
        '{sev_pkg::RPI_OFS, 32'h0000_2710}, '{sev_pkg::OVF_OFS, 32'h0000_0000},
        '{sev_pkg::FULL_OFS, 32'h0000_0000}, '{sev_pkg::ACK_OFS, 32'h0000_0000},
        '{sev_pkg::INT_STAT_OFS, 32'h0000_0000}};

    // Short tick so that 25 us is only 50 cycles
    sev_point_capture #(.TICK_DIV(2)) dut (.clk(clk), .reset(reset), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
        .point_lost_event_flag(point_lost_event_flag), .data_produce(data_produce), .irq(irq));
    sev_owner_model owner (.clk(clk), .reset(reset), .data_produce(data_produce),
        .produced(produced));

    always #12.5 clk = ~clk;

    task automatic stop_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready, then takes data and releases
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Inputs settle over several cycles so each edge is seen alone
    task automatic set_din(input logic [15:0] v);
        @(posedge clk);
        din <= v;
        repeat (4) @(posedge clk);
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0000_0000);
            `CHK(rd, rows[i].exp)
        end
        apb(1'b0, 12'h030, 32'h0000_0000);
        `CHK(err, 1'b1)
        apb(1'b1, sev_pkg::CAPEN_OFS, 32'h0001_0001);
        apb(1'b1, sev_pkg::INT_MASK_OFS, 32'h0000_0003);
        apb(1'b0, sev_pkg::TIME_OFS, 32'h0000_0000);
        t0 = rd;
        cnt0 = produced;
        set_din(16'h0001);
        `CHK(irq, 1'b1)
        `CHK(produced - cnt0, 1)
        apb(1'b0, sev_pkg::SLOT_BASE, 32'h0000_0000);
        ts = rd;
        apb(1'b0, sev_pkg::TIME_OFS, 32'h0000_0000);
        `CHK(ts >= t0 && ts <= rd, 1'b1)
        // Second off-to-on while the latched slot is still unacknowledged
        set_din(16'h0000);
        set_din(16'h0001);
        apb(1'b0, sev_pkg::SLOT_BASE, 32'h0000_0000);
        `CHK(rd, ts)
        `CHK(point_lost_event_flag, 16'h0001)
        apb(1'b0, sev_pkg::FULL_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0001_0001)
        repeat (20) @(posedge clk);
        `CHK(point_lost_event_flag, 16'h0001)
        apb(1'b1, sev_pkg::OVF_OFS, 32'hFFFF_FFFF);
        apb(1'b1, sev_pkg::INT_STAT_OFS, 32'hFFFF_FFFF);
        repeat (2) @(posedge clk);
        `CHK(point_lost_event_flag, 16'h0000)
        `CHK(irq, 1'b0)
        // Acknowledge both directions, then capture again cleanly
        apb(1'b1, sev_pkg::ACK_OFS, 32'h0001_0001);
        apb(1'b0, sev_pkg::FULL_OFS, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        set_din(16'h0000);
        set_din(16'h0001);
        `CHK(point_lost_event_flag, 16'h0000)
        apb(1'b0, sev_pkg::SLOT_BASE, 32'h0000_0000);
        `CHK(rd > ts, 1'b1)
        // Hold off: a full slot is overwritten and the loss reported
        apb(1'b1, sev_pkg::CTRL_OFS, 32'h0000_0002);
        apb(1'b0, 12'h140, 32'h0000_0000);
        ts2 = rd;
        set_din(16'h0000);
        apb(1'b0, 12'h140, 32'h0000_0000);
        `CHK(rd > ts2, 1'b1)
        `CHK(point_lost_event_flag, 16'h0001)
        // Input 1 has no capture enable in either direction
        set_din(16'h0002);
        set_din(16'h0000);
        apb(1'b0, sev_pkg::FULL_OFS, 32'h0000_0000);
        `CHK({rd[17], rd[1], point_lost_event_flag[1]}, 3'b000)
        // Two inputs rising 65 cycles (32.5 us) apart get distinct, ordered stamps
        apb(1'b1, sev_pkg::CAPEN_OFS, 32'h0001_000D);
        set_din(16'h0004);
        repeat (60) @(posedge clk);
        set_din(16'h000C);
        apb(1'b0, 12'h108, 32'h0000_0000);
        ts = rd;
        apb(1'b0, 12'h10C, 32'h0000_0000);
        `CHK(rd - ts >= 32'd25, 1'b1)
        // Pending capture status is hidden by the mask
        apb(1'b1, sev_pkg::INT_MASK_OFS, 32'h0000_0000);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        // Module-wide mode off: an enabled edge on a full slot with hold off is ignored
        cnt0 = produced;
        apb(1'b1, sev_pkg::CTRL_OFS, 32'h0000_0000);
        set_din(16'h000D);
        `CHK(produced - cnt0, 0)
        // Interval writes below the floor clamp; a packet then goes out unprompted
        apb(1'b1, sev_pkg::RPI_OFS, 32'h0000_0000);
        cnt0 = produced;
        apb(1'b0, sev_pkg::RPI_OFS, 32'h0000_0000);
        `CHK(rd, 32'(sev_pkg::RPI_MIN_US))
        // Two cycles per us with the short tick; only one interval fits
        repeat (2 * sev_pkg::RPI_MIN_US) @(posedge clk);
        `CHK(produced - cnt0, 1)
        apb(1'b0, sev_pkg::INT_STAT_OFS, 32'h0000_0000);
        `CHK(rd[sev_pkg::INT_PACKET], 1'b1)
        // Reset in mid-run drops the lost flag and restores the defaults
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        `CHK(point_lost_event_flag, 16'h0000)
        `CHK({irq, data_produce, pready}, 3'b000)
        apb(1'b0, sev_pkg::CTRL_OFS, 32'h0000_0000);
        `CHK(rd, sev_pkg::CTRL_RESET)
        apb(1'b0, sev_pkg::RPI_OFS, 32'h0000_0000);
        `CHK(rd, 32'(sev_pkg::RPI_DEFAULT_US))
        stop_test();
    end
endmodule

bind sev_point_capture sev_capture_monitor #(.N_IN(N_IN)) u_mon (.clk(clk), .reset(reset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
    .point_lost_event_flag(point_lost_event_flag), .data_produce(data_produce), .irq(irq));
